// *** src/nvmac_top.sv ***
// Register front end of the byte-wide nonvolatile data store.
`timescale 1ns/10ps
`default_nettype none
`include "nvmac_params.svh"

// Contract
// RULE1 - High address holds only bit 0, for 512 bytes; rest reads zero.
// RULE2 - Software loads the address before any array access.
// RULE3 - Linear addressing; with 128 bytes low address bit 7 reads zero.
// RULE4 - Data register feeds writes and holds the byte after a read.
// RULE5 - Mode 00 atomic 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved.
// RULE6 - Mode writes are ignored while program enable is set.
// RULE7 - Reset clears mode to 00 unless programming is running.
// RULE8 - Ready enable plus global enable gives a level interrupt when idle.
// RULE9 - Master enable clears four cycles after set; starts need it set.
// RULE10 - Program enable without master enable does nothing.
// RULE11 - Start performs the mode action; program enable holds until done.
// RULE12 - A program start halts the processor for two cycles.
// RULE13 - Read strobe loads the addressed byte and halts four cycles.
// RULE14 - While programming, read strobes and address writes are refused.
// RULE15 - Software polls program enable before a read strobe.
// RULE16 - Control bits 7 and 6 read zero; software writes bit 7 zero.
// RULE17 - A reset during programming lets the cycle finish.
// RULE18 - While busy every other array operation is refused.
module nvmac_top #(
   parameter int AW = 8,
   parameter int unsigned ATOMIC_CYC =
      `NVM_T_ATOMIC_NS / `NVM_CLK_PERIOD_NS,
   parameter int unsigned SPLIT_CYC =
      `NVM_T_SPLIT_NS / `NVM_CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] io_addr_i,
   input wire logic io_we_i,
   input wire logic io_re_i,
   input wire nvmac_pkg::nvmac_byte_t io_wdata_i,
   input wire logic global_irq_en_i,
   output nvmac_pkg::nvmac_byte_t io_rdata_o,
   output logic ready_irq_o,
   output logic cpu_halt_o
);
   import nvmac_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   nvmac_mode_e mode_reg, mode_next;
   logic rie_reg, rie_next;
   logic [2:0] mpe_cnt_reg, mpe_cnt_next;
   logic [AW-1:0] addr_reg, addr_next;
   nvmac_byte_t data_reg, data_next;
   logic rd_pend_reg, rd_pend_next;
   logic [2:0] halt_cnt_reg, halt_cnt_next;
   logic halt_reg, halt_next;
   logic irq_reg, irq_next;
   nvmac_byte_t rdata_reg, rdata_next;

   logic busy;
   logic ctrl_we;
   logic mpe_write;
   logic prog_start;
   logic rd_accept;
   logic addr_we;
   logic [8:0] addr_ext;
   nvmac_byte_t mem_rdata;
   logic mem_wr;
   nvmac_mode_e mem_op;
   logic [AW-1:0] mem_addr;
   nvmac_byte_t mem_wdata;

   function automatic logic [AW-1:0] fit_addr(input logic [8:0] full);
      return full[AW-1:0];
   endfunction : fit_addr

   // ----------------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------------
   assign addr_ext = 9'(addr_reg);
   assign ctrl_we = io_we_i && io_addr_i == `NVM_CONTROL_OFS;
   assign mpe_write = ctrl_we && io_wdata_i[`NVM_MASTER_PROG_BIT];
   // RULE10 start needs master enable.
   assign prog_start = ctrl_we && io_wdata_i[`NVM_PROG_ENABLE_BIT]
                       && mpe_cnt_reg != 3'h0 && !busy
                       && mode_reg != MODE_RESERVED && resetn_i;
   // RULE14 reads refused while busy.
   assign rd_accept = ctrl_we && io_wdata_i[`NVM_READ_STROBE_BIT]
                      && !busy && resetn_i;
   assign addr_we = io_we_i && !busy
                    && (io_addr_i == `NVM_ADDRESS_LOW_OFS
                        || io_addr_i == `NVM_ADDRESS_HIGH_OFS);

   // ----------------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------------
   always_comb begin
      mode_next = mode_reg;
      rie_next = rie_reg;
      mpe_cnt_next = mpe_cnt_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      rd_pend_next = rd_accept;
      // RULE9 master enable countdown.
      if (mpe_cnt_reg != 3'h0) begin
         mpe_cnt_next = mpe_cnt_reg - 3'h1;
      end
      if (mpe_write) begin
         mpe_cnt_next = `NVM_MASTER_WINDOW;
      end
      if (ctrl_we) begin
         rie_next = io_wdata_i[`NVM_READY_IRQ_BIT];
         // RULE6 mode frozen while programming.
         if (!busy) begin
            mode_next = nvmac_mode_e'(io_wdata_i[`NVM_PROG_MODE_HI_BIT:
                                                 `NVM_PROG_MODE_LO_BIT]);
         end
      end
      // RULE14 address frozen while busy.
      if (addr_we && io_addr_i == `NVM_ADDRESS_LOW_OFS) begin
         addr_next = fit_addr({addr_ext[8], io_wdata_i});
      end
      if (addr_we && io_addr_i == `NVM_ADDRESS_HIGH_OFS) begin
         addr_next = fit_addr({io_wdata_i[0], addr_ext[7:0]});
      end
      // RULE18 data writes refused while the array is busy; reset still clears data.
      if (io_we_i && io_addr_i == `NVM_DATA_OFS && !busy) begin
         data_next = io_wdata_i;
      end
      // RULE4 fetched byte lands in data.
      if (rd_pend_reg) begin
         data_next = mem_rdata;
      end
      if (!resetn_i) begin
         rie_next = 1'b0;
         mpe_cnt_next = 3'h0;
         rd_pend_next = 1'b0;
         data_next = `NVM_DATA_RESET;
         // RULE7 mode reset unless busy.
         if (!busy) begin
            mode_next = MODE_ATOMIC;
            addr_next = fit_addr(`NVM_ADDRESS_RESET);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Halt, interrupt and read data
   // ----------------------------------------------------------------------
   always_comb begin
      halt_cnt_next = halt_cnt_reg;
      if (halt_cnt_reg != 3'h0) begin
         halt_cnt_next = halt_cnt_reg - 3'h1;
      end
      // RULE12 two halt cycles on start.
      if (prog_start) begin
         halt_cnt_next = `NVM_HALT_PROG;
      end
      // RULE13 four halt cycles on read.
      if (rd_accept) begin
         halt_cnt_next = `NVM_HALT_READ;
      end
      if (!resetn_i) begin
         halt_cnt_next = 3'h0;
      end
      halt_next = halt_cnt_next != 3'h0;
      // RULE8 level interrupt while idle.
      irq_next = rie_next && global_irq_en_i && !busy && resetn_i;
      rdata_next = 8'h00;
      if (io_re_i) begin
         unique case (io_addr_i)
            // RULE16 top control bits read zero.
            `NVM_CONTROL_OFS:
               rdata_next = {2'b00, mode_reg, rie_reg,
                             mpe_cnt_reg != 3'h0, busy, 1'b0};
            `NVM_DATA_OFS: rdata_next = data_reg;
            // RULE3 missing low bits read zero.
            `NVM_ADDRESS_LOW_OFS: rdata_next = addr_ext[7:0];
            // RULE1 only bit 0 of high address.
            `NVM_ADDRESS_HIGH_OFS: rdata_next = {7'h00, addr_ext[8]};
            default: rdata_next = 8'h00;
         endcase
      end
      if (!resetn_i) begin
         rdata_next = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      mode_reg <= mode_next;
      rie_reg <= rie_next;
      mpe_cnt_reg <= mpe_cnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      rd_pend_reg <= rd_pend_next;
      halt_cnt_reg <= halt_cnt_next;
      halt_reg <= halt_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
   end

   assign io_rdata_o = rdata_reg;
   assign ready_irq_o = irq_reg;
   assign cpu_halt_o = halt_reg;

   // ----------------------------------------------------------------------
   // Program sequencer and array
   // ----------------------------------------------------------------------
   // RULE11 start latches mode, address and data.
   nvmac_prog #(
      .AW(AW),
      .ATOMIC_CYC(ATOMIC_CYC),
      .SPLIT_CYC(SPLIT_CYC)
   ) u_prog (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(prog_start),
      .mode_i(mode_reg),
      .addr_i(addr_reg),
      .data_i(data_reg),
      .busy_o(busy),
      .mem_wr_o(mem_wr),
      .mem_op_o(mem_op),
      .mem_addr_o(mem_addr),
      .mem_data_o(mem_wdata)
   );

   nvmac_mem #(
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .rd_en_i(rd_accept),
      .rd_addr_i(addr_reg),
      .wr_en_i(mem_wr),
      .wr_op_i(mem_op),
      .wr_addr_i(mem_addr),
      .wr_data_i(mem_wdata),
      .rd_data_o(mem_rdata)
   );

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   addr_high_zero_a: assert property ( // RULE1
      @(posedge clk_i) disable iff (!resetn_i)
      io_re_i && io_addr_i == `NVM_ADDRESS_HIGH_OFS
      |=> io_rdata_o[7:1] == 7'h00)
      else $error("High address reads nonzero upper bits.");

   ctrl_top_zero_a: assert property ( // RULE16
      @(posedge clk_i) disable iff (!resetn_i)
      io_re_i && io_addr_i == `NVM_CONTROL_OFS
      |=> io_rdata_o[7:6] == 2'b00 && io_rdata_o[1] == $past(busy))
      else $error("Control read shows wrong top bits or busy.");

   master_count_a: assert property ( // RULE9
      @(posedge clk_i) disable iff (!resetn_i)
      mpe_write ##1 !mpe_write [*4] |=> mpe_cnt_reg == 3'h0)
      else $error("Master enable outlived its four cycles.");

   mode_frozen_a: assert property ( // RULE6
      @(posedge clk_i) busy |=> mode_reg == $past(mode_reg))
      else $error("Mode changed while programming.");

   mode_reset_a: assert property ( // RULE7
      @(posedge clk_i) !resetn_i && !busy |=> mode_reg == MODE_ATOMIC)
      else $error("Mode not cleared by an idle reset.");

   ready_level_a: assert property ( // RULE8
      @(posedge clk_i) disable iff (!resetn_i)
      (rie_reg && global_irq_en_i && !busy) [*2] |-> ready_irq_o)
      else $error("Ready interrupt missing while idle and enabled.");

   start_gated_a: assert property ( // RULE10
      @(posedge clk_i) disable iff (!resetn_i)
      prog_start |-> mpe_cnt_reg != 3'h0 ##1 busy)
      else $error("Program start without master enable or busy.");

   prog_halt_a: assert property ( // RULE12
      @(posedge clk_i) disable iff (!resetn_i)
      prog_start |=> cpu_halt_o [*2] ##1 !cpu_halt_o)
      else $error("Program start halt is not two cycles.");

   read_halt_a: assert property ( // RULE13
      @(posedge clk_i) disable iff (!resetn_i)
      rd_accept |=> cpu_halt_o [*4] ##1 !cpu_halt_o)
      else $error("Read halt is not four cycles.");

   read_load_a: assert property ( // RULE4
      @(posedge clk_i) disable iff (!resetn_i)
      rd_accept ##1 resetn_i |=> data_reg == $past(mem_rdata))
      else $error("Fetched byte not loaded into data.");

   busy_refuse_a: assert property ( // RULE14
      @(posedge clk_i) busy |=> addr_reg == $past(addr_reg) && !rd_pend_reg)
      else $error("Address or read accepted while programming.");

endmodule : nvmac_top

`default_nettype wire

// *** src/nvmac_params.svh ***
// Offsets, bit positions and timing constants of the data store control.
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets in the I/O space
// ----------------------------------------------------------------------
`define NVM_CONTROL_OFS 6'h1c
`define NVM_DATA_OFS 6'h1d
`define NVM_ADDRESS_LOW_OFS 6'h1e
`define NVM_ADDRESS_HIGH_OFS 6'h1f

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define NVM_READ_STROBE_BIT 0
`define NVM_PROG_ENABLE_BIT 1
`define NVM_MASTER_PROG_BIT 2
`define NVM_READY_IRQ_BIT 3
`define NVM_PROG_MODE_LO_BIT 4
`define NVM_PROG_MODE_HI_BIT 5

// ----------------------------------------------------------------------
// Reset values and cycle counts
// ----------------------------------------------------------------------
`define NVM_DATA_RESET 8'h00
`define NVM_ADDRESS_RESET 9'h000
`define NVM_ERASED_BYTE 8'hff
`define NVM_MASTER_WINDOW 3'h4
`define NVM_HALT_PROG 3'h2
`define NVM_HALT_READ 3'h4

// ----------------------------------------------------------------------
// Programming times
// ----------------------------------------------------------------------
`define NVM_CLK_PERIOD_NS 8
`define NVM_T_ATOMIC_NS 3400000
`define NVM_T_SPLIT_NS 1800000

`endif

// *** src/nvmac_pkg.sv ***
// Types shared by the data store control modules.
package nvmac_pkg;

   typedef enum logic [1:0] {
      MODE_ATOMIC,
      MODE_ERASE,
      MODE_WRITE,
      MODE_RESERVED
   } nvmac_mode_e;

   typedef enum logic {
      PROG_IDLE,
      PROG_RUN
   } nvmac_state_e;

   typedef logic [7:0] nvmac_byte_t;

endpackage : nvmac_pkg

// *** src/nvmac_mem.sv ***
// Byte array of the data store with a registered read port.
`timescale 1ns/10ps
`default_nettype none
`include "nvmac_params.svh"

module nvmac_mem #(
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   input wire logic wr_en_i,
   input wire nvmac_pkg::nvmac_mode_e wr_op_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire nvmac_pkg::nvmac_byte_t wr_data_i,
   output nvmac_pkg::nvmac_byte_t rd_data_o
);
   import nvmac_pkg::*;

   nvmac_byte_t mem_reg [0:(1<<AW)-1];
   nvmac_byte_t rd_data_reg;

   // ----------------------------------------------------------------------
   // Array update
   // ----------------------------------------------------------------------
   // A write-only cycle can only clear bits, so an unerased cell mixes data.
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         unique case (wr_op_i)
            MODE_ATOMIC: mem_reg[wr_addr_i] <= wr_data_i;
            MODE_ERASE: mem_reg[wr_addr_i] <= `NVM_ERASED_BYTE;
            MODE_WRITE: mem_reg[wr_addr_i] <= mem_reg[wr_addr_i] & wr_data_i;
            MODE_RESERVED: mem_reg[wr_addr_i] <= mem_reg[wr_addr_i];
         endcase
      end
      if (rd_en_i) begin
         rd_data_reg <= mem_reg[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_reg;

endmodule : nvmac_mem

`default_nettype wire

// *** src/nvmac_prog.sv ***
// Timed programming cycle that survives a reset while it runs.
`timescale 1ns/10ps
`default_nettype none

module nvmac_prog #(
   parameter int AW = 8,
   parameter int unsigned ATOMIC_CYC = 425000,
   parameter int unsigned SPLIT_CYC = 225000
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire nvmac_pkg::nvmac_mode_e mode_i,
   input wire logic [AW-1:0] addr_i,
   input wire nvmac_pkg::nvmac_byte_t data_i,
   output logic busy_o,
   output logic mem_wr_o,
   output nvmac_pkg::nvmac_mode_e mem_op_o,
   output logic [AW-1:0] mem_addr_o,
   output nvmac_pkg::nvmac_byte_t mem_data_o
);
   import nvmac_pkg::*;

   nvmac_state_e state_reg, state_next;
   logic [19:0] cnt_reg, cnt_next;
   logic wr_reg, wr_next;
   nvmac_mode_e op_reg, op_next;
   logic [AW-1:0] addr_reg, addr_next;
   nvmac_byte_t data_reg, data_next;

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      wr_next = 1'b0;
      op_next = op_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      unique case (state_reg)
         PROG_IDLE: begin
            if (start_i && !wr_reg) begin
               state_next = PROG_RUN;
               op_next = mode_i;
               addr_next = addr_i;
               data_next = data_i;
               // RULE5 time per mode.
               cnt_next = (mode_i == MODE_ATOMIC) ? 20'(ATOMIC_CYC - 1)
                                                  : 20'(SPLIT_CYC - 1);
            end
         end
         PROG_RUN: begin
            cnt_next = cnt_reg - 20'h00001;
            if (cnt_reg == 20'h00000) begin
               state_next = PROG_IDLE;
               wr_next = 1'b1;
            end
         end
      endcase
      // RULE17 reset spares a running cycle.
      // An unknown state at power-up takes the idle arm, so reset settles it.
      if (!resetn_i) begin
         if (state_reg == PROG_RUN) begin
            // A running cycle keeps its count and commits as planned.
         end else begin
            state_next = PROG_IDLE;
            cnt_next = 20'h00000;
            op_next = MODE_ATOMIC;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
   end

   // The commit cycle still counts as busy so a read never races it.
   assign busy_o = (state_reg == PROG_RUN) || wr_reg;
   assign mem_wr_o = wr_reg;
   assign mem_op_o = op_reg;
   assign mem_addr_o = addr_reg;
   assign mem_data_o = data_reg;

   // RULE11 commit after the full time.
   prog_commit_a: assert property ( // RULE11
      @(posedge clk_i) $rose(wr_reg) |->
         $past(cnt_reg) == 20'h00000 && $past(state_reg) == PROG_RUN)
      else $error("Array committed before the programming time ended.");

endmodule : nvmac_prog

`default_nettype wire

// *** verification/nvmac_top_tb.sv ***
// Self-checking testbench for the data store register front end.
`timescale 1ns/10ps
`default_nettype none
`include "nvmac_params.svh"

module nvmac_top_tb;
   import nvmac_pkg::*;

   // -------------------------------------------------------------------
   // Short programming times keep the run brief.
   // -------------------------------------------------------------------
   localparam int unsigned ATOM = 20;
   localparam int unsigned SPLT = 10;
   localparam logic [5:0] OFS_C = `NVM_CONTROL_OFS;
   localparam logic [5:0] OFS_D = `NVM_DATA_OFS;
   localparam logic [5:0] OFS_L = `NVM_ADDRESS_LOW_OFS;
   localparam logic [5:0] OFS_H = `NVM_ADDRESS_HIGH_OFS;

   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [5:0] io_addr_i = 6'h00;
   logic io_we_i = 1'b0;
   logic io_re_i = 1'b0;
   nvmac_byte_t io_wdata_i = 8'h00;
   logic global_irq_en_i = 1'b0;
   nvmac_byte_t io_rdata_o;
   logic ready_irq_o;
   logic cpu_halt_o;
   int err_total = 0;
   int tests_run = 0;
   int halt_cnt = 0;
   int h0 = 0;
   int n;
   nvmac_byte_t d;

   nvmac_top #(.AW(8), .ATOMIC_CYC(ATOM), .SPLIT_CYC(SPLT)) u_dut (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .io_addr_i(io_addr_i),
      .io_we_i(io_we_i),
      .io_re_i(io_re_i),
      .io_wdata_i(io_wdata_i),
      .global_irq_en_i(global_irq_en_i),
      .io_rdata_o(io_rdata_o),
      .ready_irq_o(ready_irq_o),
      .cpu_halt_o(cpu_halt_o)
   );

   always #4 clk_i = ~clk_i;

   // Halt cycles are counted here so that no single sample can miss one.
   always @(posedge clk_i) begin
      if (cpu_halt_o === 1'b1) halt_cnt <= halt_cnt + 1;
   end

   // -------------------------------------------------------------------
   // Access and compare tasks
   // -------------------------------------------------------------------
   task chk_byte(input nvmac_byte_t got, input nvmac_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte

   task chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // Each access begins at its own falling edge, so strobes never toggle
   // twice in one time step.
   task wr(input logic [5:0] a, input nvmac_byte_t v);
      @(negedge clk_i);
      io_addr_i = a;
      io_wdata_i = v;
      io_we_i = 1'b1;
      @(negedge clk_i);
      io_we_i = 1'b0;
   endtask : wr

   task rd(input logic [5:0] a, output nvmac_byte_t v);
      @(negedge clk_i);
      io_addr_i = a;
      io_re_i = 1'b1;
      @(negedge clk_i);
      v = io_rdata_o;
      io_re_i = 1'b0;
   endtask : rd

   // Reads the control register every cycle and counts busy cycles.
   task poll(output int cnt);
      int k;
      cnt = 0;
      @(negedge clk_i);
      io_addr_i = OFS_C;
      io_re_i = 1'b1;
      for (k = 0; k < 1000; k++) begin
         @(negedge clk_i);
         if (io_rdata_o[1] === 1'b1) cnt++;
         else if (k > 1) break;
      end
      io_re_i = 1'b0;
   endtask : poll

   task start(input logic [1:0] m);
      wr(OFS_C, {2'b00, m, 4'h4});
      wr(OFS_C, {2'b00, m, 4'h2});
   endtask : start

   task rst(input int c);
      @(negedge clk_i);
      resetn_i = 1'b0;
      repeat (c) @(negedge clk_i);
      resetn_i = 1'b1;
   endtask : rst

   task give_verdict;
      $display("mismatches %0d, comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   // -------------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (12) @(negedge clk_i);
      resetn_i = 1'b1;
      global_irq_en_i = 1'b1;
      rd(OFS_C, d);
      chk_byte(d, 8'h00);
      rd(OFS_D, d);
      chk_byte(d, 8'h00);
      wr(OFS_H, 8'hff);
      rd(OFS_H, d);
      chk_byte(d, 8'h00);
      wr(OFS_L, 8'h5a);
      rd(OFS_L, d);
      chk_byte(d, 8'h5a);
      // An unmapped place reads zero and drops writes.
      wr(6'h10, 8'h77);
      rd(6'h10, d);
      chk_byte(d, 8'h00);
      // Bit 7 is written zero; bit 6 is set to show that it reads zero.
      wr(OFS_C, 8'h48);
      rd(OFS_C, d);
      chk_byte(d, 8'h08);
      chk_bit(ready_irq_o, 1'b1);
      global_irq_en_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk_bit(ready_irq_o, 1'b0);
      global_irq_en_i = 1'b1;
      wr(OFS_C, 8'h00);
      repeat (2) @(negedge clk_i);
      chk_bit(ready_irq_o, 1'b0);
      h0 = halt_cnt;
      wr(OFS_C, 8'h02);
      rd(OFS_C, d);
      chk_byte(d, 8'h00);
      wr(OFS_C, 8'h04);
      rd(OFS_C, d);
      chk_byte(d, 8'h04);
      repeat (6) @(negedge clk_i);
      rd(OFS_C, d);
      chk_byte(d, 8'h00);
      wr(OFS_C, 8'h04);
      repeat (4) @(negedge clk_i);
      wr(OFS_C, 8'h02);
      rd(OFS_C, d);
      chk_byte(d, 8'h00);
      chk_byte(nvmac_byte_t'(halt_cnt - h0), 8'h00);
      // Atomic cycle, then read back through the strobe.
      wr(OFS_D, 8'h3c);
      h0 = halt_cnt;
      start(2'b00);
      poll(n);
      chk_bit(logic'(n >= ATOM && n <= ATOM + 4), 1'b1);
      chk_byte(nvmac_byte_t'(halt_cnt - h0), 8'h02);
      h0 = halt_cnt;
      wr(OFS_C, 8'h01);
      repeat (6) @(negedge clk_i);
      chk_byte(nvmac_byte_t'(halt_cnt - h0), 8'h04);
      rd(OFS_D, d);
      chk_byte(d, 8'h3c);
      // Erase cycle with refused accesses while busy.
      h0 = halt_cnt;
      start(2'b01);
      wr(OFS_C, 8'h29);
      rd(OFS_C, d);
      chk_byte(d & 8'hfb, 8'h1a);
      chk_bit(ready_irq_o, 1'b0);
      wr(OFS_L, 8'h11);
      wr(OFS_D, 8'h99);
      poll(n);
      repeat (2) @(negedge clk_i);
      chk_byte(nvmac_byte_t'(halt_cnt - h0), 8'h02);
      chk_bit(ready_irq_o, 1'b1);
      rd(OFS_L, d);
      chk_byte(d, 8'h5a);
      rd(OFS_D, d);
      chk_byte(d, 8'h3c);
      wr(OFS_C, 8'h11);
      repeat (6) @(negedge clk_i);
      rd(OFS_D, d);
      chk_byte(d, 8'hff);
      // Write-only cycle on the erased cell.
      wr(OFS_D, 8'ha5);
      start(2'b10);
      poll(n);
      chk_bit(logic'(n >= SPLT && n <= SPLT + 4), 1'b1);
      wr(OFS_C, 8'h21);
      repeat (6) @(negedge clk_i);
      rd(OFS_D, d);
      chk_byte(d, 8'ha5);
      // The reserved mode starts nothing.
      h0 = halt_cnt;
      start(2'b11);
      repeat (6) @(negedge clk_i);
      rd(OFS_C, d);
      chk_byte(d, 8'h30);
      chk_byte(nvmac_byte_t'(halt_cnt - h0), 8'h00);
      // Reset in mid-cycle must not abort the erase.
      start(2'b01);
      rst(2);
      rd(OFS_C, d);
      chk_byte(d & 8'hfb, 8'h12);
      rd(OFS_D, d);
      chk_byte(d, 8'h00);
      poll(n);
      rd(OFS_L, d);
      chk_byte(d, 8'h5a);
      wr(OFS_C, 8'h11);
      repeat (6) @(negedge clk_i);
      rd(OFS_D, d);
      chk_byte(d, 8'hff);
      wr(OFS_C, 8'h20);
      rst(2);
      rd(OFS_C, d);
      chk_byte(d, 8'h00);
      give_verdict();
   end

   // The sequence needs well under a thousand cycles; this cuts a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      give_verdict();
   end

endmodule : nvmac_top_tb

`default_nettype wire
